// [dv/testbench.sv]
// Purpose: Testbench for the pin control block
// Assumes: Two channels
// Notes: Pin results queued, checked on each count tick
`timescale 1ns/10ps
module testbench import tpc_pkg::*; ;
  logic ref_clk = 0, rst_n = 0, cas = 0, ft = 0, run = 0, ext, ptk, ce;
  logic [1:0] css = CLK_BUS, drv = 0, po, oe, pi, cev, cm;
  logic [15:0] r;
  tpc_cnt_t cnt = '0;
  tpc_ch_cfg_t [1:0] cfg = '0;
  int num_errors = 0, cmp_count = 0, nc, np;
  logic q[$];
  always #2 ref_clk = ~ref_clk;
  tpc_pin_ctrl dut (.ref_clk, .rst_n, .clock_source_select(css), .center_aligned_select(cas),
    .fixed_clock_tick(ft), .ext_counter_clock_in(ext), .cnt, .ch_cfg(cfg), .channel_pin_in(pi),
    .channel_pin_out(po), .channel_pin_oe_n(oe), .prescaler_clock_tick(ptk),
    .counter_enable(ce), .capture_event(cev), .compare_match(cm));
  tpc_pins far (.drv, .ref_clk, .run, .pin_out(po), .oe_n(oe), .pin_in(pi), .ext);
  task step(int k = 1); repeat (k) @(posedge ref_clk); #1 ft = 1'($urandom); endtask
  task chk(logic a, b);
    cmp_count++;
    if (a !== b) $display("Error %0t: mismatch", $time);
    if (a !== b) num_errors++;
  endtask
  task tk(logic [1:0] m, e, logic [15:0] v, logic d, x);
    cfg[0] = '{m, e, r};
    cnt = '{1'b1, d, v};
    q.push_back(x);
    step;
    cnt.count_tick = 0;
    step;
  endtask
  always @(posedge ref_clk) if (cnt.count_tick) #2 chk(po[0], q.size() ? q.pop_front() : !po[0]);
  always @(negedge ref_clk) np += (ptk === 1'b1);
  always @(negedge ref_clk) nc += (cev[1] === 1'b1);
  task summarize;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    void'($urandom(55399));
    r = 16'($urandom) | 16'h0001;
    step(4);
    rst_n = 1;
    step;
    tk(MODE_COMPARE, ELS_TOGGLE, r, 0, 1);
    tk(MODE_COMPARE, ELS_TOGGLE, r + 16'h1, 0, 1);
    tk(MODE_COMPARE, ELS_TOGGLE, r, 0, 0);
    tk(MODE_COMPARE, ELS_SET, r, 0, 1);
    tk(MODE_COMPARE, ELS_CLEAR, r, 0, 0);
    for (int e = 2; e < 4; e++) begin
      tk({1'b1, e[0]}, e[1:0], CNT_ZERO, 0, !e[0]);
      tk({1'b1, e[0]}, e[1:0], r, 0, e[0]);
    end
    cas = 1;
    cfg[1].edge_level_select = ELS_SET;
    for (int k = 0; k < 4; k++) tk(MODE_CAPTURE, {1'b1, k[1]}, r, k[0], k[1] ^ k[0]);
    chk(oe === 2'b00, 1);
    cas = 0;
    cfg[1] = '{MODE_CAPTURE, ELS_OFF, r};
    for (int e = 1; e < 4; e++) begin
      cfg[1].edge_level_select = e[1:0];
      nc = 0;
      drv[1] = 1;
      step(4);
      drv[1] = 0;
      step(8);
      chk(nc == (e == 3 ? 2 : 1), 1);
    end
    chk(oe[1], 1);
    css = CLK_EXT;
    cfg = '0;
    np = 0;
    run = 1;
    step(64);
    run = 0;
    step(8);
    chk(np == 8, 1);
    cfg[0] = '{MODE_COMPARE, ELS_OFF, r};
    cnt = '{1'b1, 1'b0, r};
    q.push_back(po[0]);
    #1 chk(cm[0], 1'b1);
    step;
    cnt.count_tick = 0;
    chk(oe[0], 1);
    for (int c = 0; c < 4; c++) begin
      css = c[1:0];
      step;
      chk(ce, c != 0);
    end
    cfg[0] = '{MODE_COMPARE, ELS_SET, r};
    css = CLK_NONE;
    step;
    chk(oe[0], 1);
    chk(q.size() == 0, 1);
    summarize;
  end
  initial begin
    #20000;
    num_errors++;
    summarize;
  end
endmodule

// [dv/tpc_chk.sv]
// Purpose: Port assertions
// Assumes: Channel 0 pin logic, channel 1 capture
// Notes: Bound to every instance
`timescale 1ns/10ps
module tpc_chk import tpc_pkg::*; #(parameter int NUM_CH = 2) (
  // Inputs
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [1:0] clock_source_select,
  input wire logic center_aligned_select,
  input wire logic fixed_clock_tick,
  input wire tpc_cnt_t cnt,
  input wire tpc_ch_cfg_t [NUM_CH-1:0] ch_cfg,
  // Outputs
  input wire logic [NUM_CH-1:0] channel_pin_out,
  input wire logic [NUM_CH-1:0] channel_pin_oe_n,
  input wire logic prescaler_clock_tick,
  input wire logic counter_enable,
  input wire logic [NUM_CH-1:0] capture_event,
  input wire logic [NUM_CH-1:0] compare_match
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire [1:0] m = ch_cfg[0].channel_mode_select;
  wire [1:0] e = ch_cfg[0].edge_level_select;
  wire [1:0] s = clock_source_select;
  wire c = center_aligned_select;
  wire p = channel_pin_out[0];
  wire hit = cnt.count_tick && cnt.counter_value == ch_cfg[0].channel_value;
  wire on = e != ELS_OFF && s != CLK_NONE;
  wire cm_want = hit && s != CLK_NONE &&
    (c ? e != ELS_OFF : (m == MODE_COMPARE || (m[1] && e != ELS_OFF)));
  property p_cm; compare_match[0] == cm_want; endproperty
  a_cm: assert property (p_cm) else $error("compare match");
  property p_en; counter_enable == (s != CLK_NONE); endproperty
  a_en: assert property (p_en) else $error("enable");
  property p_rel; !on || (!c && m == MODE_CAPTURE) |-> channel_pin_oe_n[0]; endproperty
  a_rel: assert property (p_rel) else $error("release");
  property p_drv; on && (c || m != MODE_CAPTURE) |-> !channel_pin_oe_n[0]; endproperty
  a_drv: assert property (p_drv) else $error("drive");
  property p_cap; capture_event[1] |-> !c && ch_cfg[1].channel_mode_select == MODE_CAPTURE
    && ch_cfg[1].edge_level_select != ELS_OFF; endproperty
  a_cap: assert property (p_cap) else $error("capture");
  property p_oc; on && !c && m == MODE_COMPARE && e[1] && hit |=> p == $past(e[0]); endproperty
  a_oc: assert property (p_oc) else $error("set clear");
  property p_tg; on && !c && m == MODE_COMPARE && e == ELS_TOGGLE && hit |=> p != $past(p);
  endproperty
  a_tg: assert property (p_tg) else $error("toggle");
  property p_ep; on && !c && m[1] && cnt.count_tick && cnt.counter_value == CNT_ZERO && !hit
    |=> p == !$past(e[0]); endproperty
  a_ep: assert property (p_ep) else $error("edge pwm");
  property p_cp; on && c && hit |=> p == ($past(e[0]) ^ $past(cnt.count_down)); endproperty
  a_cp: assert property (p_cp) else $error("center pwm");
  property p_ck; s != CLK_EXT |-> prescaler_clock_tick ==
    (s == CLK_BUS || s == CLK_FIXED && fixed_clock_tick); endproperty
  a_ck: assert property (p_ck) else $error("clock");
  c_oc: cover property (on && m == MODE_COMPARE && hit);
  c_cp: cover property (on && c && hit);
  c_cap: cover property (capture_event[1]);
endmodule
bind tpc_pin_ctrl tpc_chk #(.NUM_CH(NUM_CH)) u_chk (.*);

// [dv/tpc_pins.sv]
// Purpose: Far side circuitry on channel and clock pins
// Assumes: Bench sets channel levels through drv
// Notes: Clock pin stays low outside frames
`timescale 1ns/10ps
module tpc_pins (
  // Control
  input  wire logic [1:0] drv,
  input  wire logic       ref_clk,
  input  wire logic       run,
  // Pins
  input  wire logic [1:0] pin_out,
  input  wire logic [1:0] oe_n,
  output logic      [1:0] pin_in,
  output logic            ext
);
  logic [2:0] k = 3'h0;
  always @(posedge ref_clk) if (run) k <= k + 3'h1;
  assign ext = run & k[2];
  assign pin_in = oe_n & drv | ~oe_n & pin_out;
endmodule

// [verilog/tpc_pin_ctrl.sv]
// Purpose: Clock source selection and per-channel pin control of a timer/PWM unit
// Assumes: Counter and prescaler live outside; counter state arrives as an input
// Notes: Pin output enable is low while the unit drives the pin
`timescale 1ns/10ps
module tpc_pin_ctrl import tpc_pkg::*; #(
  parameter int NUM_CH = 2
) (
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  // Unit configuration and clock inputs
  input  wire logic [1:0]               clock_source_select,
  input  wire logic                     center_aligned_select,
  input  wire logic                     fixed_clock_tick,
  input  wire logic                     ext_counter_clock_in,
  // Counter state
  input  wire tpc_cnt_t                 cnt,
  // Channel configuration
  input  wire tpc_ch_cfg_t [NUM_CH-1:0] ch_cfg,
  // Channel pins
  input  wire logic [NUM_CH-1:0]        channel_pin_in,
  output logic [NUM_CH-1:0]             channel_pin_out,
  output logic [NUM_CH-1:0]             channel_pin_oe_n,
  // Status towards the counter side
  output logic                          prescaler_clock_tick,
  output logic                          counter_enable,
  output logic [NUM_CH-1:0]             capture_event,
  output logic [NUM_CH-1:0]             compare_match
);

  // External clock synchronizer and edge detect
  logic ext_sync1;
  logic ext_sync2;
  logic ext_prev;
  wire  ext_rise = ext_sync2 & ~ext_prev;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_sync1 <= 1'b0;
      ext_sync2 <= 1'b0;
      ext_prev  <= 1'b0;
    end else begin
      ext_sync1 <= ext_counter_clock_in;
      ext_sync2 <= ext_sync1;
      ext_prev  <= ext_sync2;
    end
  end

  // Clock source selection
  wire  clk_off = (clock_source_select == CLK_NONE);
  logic next_tick;

  always_comb begin
    unique case (clock_source_select)
      CLK_NONE:  next_tick = 1'b0;
      CLK_BUS:   next_tick = 1'b1;
      CLK_FIXED: next_tick = fixed_clock_tick;
      CLK_EXT:   next_tick = ext_rise;
    endcase
  end

  assign prescaler_clock_tick = next_tick;
  assign counter_enable       = ~clk_off;

  // Per-channel pin logic
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      wire [1:0] els     = ch_cfg[g].edge_level_select;
      wire [1:0] ms      = ch_cfg[g].channel_mode_select;
      wire       active  = (els != ELS_OFF) && !clk_off;
      wire       is_swt  = (els == ELS_OFF) && !clk_off && !center_aligned_select &&
                           (ms == MODE_COMPARE);
      wire       cpwm    = active && center_aligned_select;
      wire       is_cap  = active && !center_aligned_select && (ms == MODE_CAPTURE);
      wire       is_oc   = active && !center_aligned_select && (ms == MODE_COMPARE);
      wire       is_epwm = active && !center_aligned_select && ms[1];
      wire       drive   = cpwm || is_oc || is_epwm;
      wire       match   = (cnt.counter_value == ch_cfg[g].channel_value);
      wire       hit     = match && cnt.count_tick;
      wire       period0 = cnt.count_tick && (cnt.counter_value == CNT_ZERO);

      logic pin_s1;
      logic pin_s2;
      logic pin_prev;
      logic pin_level;
      logic next_level;

      wire  rise = pin_s2 & ~pin_prev;
      wire  fall = ~pin_s2 & pin_prev;

      always_comb begin
        next_level = pin_level;
        if (is_oc && hit) begin
          unique case (els)
            ELS_TOGGLE: next_level = ~pin_level;
            ELS_CLEAR:  next_level = 1'b0;
            ELS_SET:    next_level = 1'b1;
            default:    next_level = pin_level;
          endcase
        end else if (is_epwm) begin
          if (hit)
            next_level = els[0];
          else if (period0)
            next_level = ~els[0];
        end else if (cpwm && hit) begin
          next_level = cnt.count_down ^ els[0];
        end
      end

      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          pin_s1    <= 1'b0;
          pin_s2    <= 1'b0;
          pin_prev  <= 1'b0;
          pin_level <= PIN_INIT;
        end else begin
          pin_s1    <= channel_pin_in[g];
          pin_s2    <= pin_s1;
          pin_prev  <= pin_s2;
          pin_level <= next_level;
        end
      end

      // Capture edge selection
      assign capture_event[g] = is_cap && ((els == ELS_RISE) ? rise :
                                           (els == ELS_FALL) ? fall :
                                           (rise | fall));
      assign compare_match[g]    = (is_oc || is_epwm || cpwm || is_swt) && hit;
      assign channel_pin_out[g]  = pin_level;
      assign channel_pin_oe_n[g] = ~drive;
    end
  endgenerate

endmodule

// [verilog/tpc_pkg.sv]
// Purpose: Constants and types for the timer channel pin control block
// Assumes: One bus clock; pins sampled synchronously
// Notes:
// What this block does
// - Counter clock source: none, bus rate, fixed clock or external input.
// - External clock input passes a bus-clock synchronizer before the prescaler.
// - With edge/level select zero and a clock selected, output compare still flags matches with pin released.
// - Channel releases its pin when edge/level select or clock select is zero.
// - Center-aligned select with nonzero edge/level makes channel drive center PWM.
// - Without center-aligned select, mode select picks capture, compare or edge PWM.
// - Input capture makes the pin an edge input; edge/level picks edges.
// - Capture edges synchronized; pulses must last over one bus clock.
// - Output compare overrides direction and drives the pin.
// - On each compare match the pin toggles, clears or sets.
// - Toggle first selected keeps previous level until next match.
// - Edge PWM drives the pin; low edge/level bit sets polarity.
// - Edge PWM code 1:0 goes high at zero, low at match.
// - Edge PWM low bit set goes low at zero, high at match.
// - Center PWM drives each channel pin with nonzero edge/level select as output.
// - Center PWM code 1:0 clears on match counting up, sets counting down.
// - Center PWM low bit set sets on match up, clears on match down.
// - One to eight channels, each with its own pin.
// - Clock select 00 none, 01 bus rate, 10 fixed clock, 11 external.
package tpc_pkg;

  localparam int          CNT_W         = 16;
  localparam int          NUM_CH_MAX    = 8;
  localparam logic [15:0] CNT_ZERO      = 16'h0000;

  localparam logic [1:0]  CLK_NONE      = 2'h0;
  localparam logic [1:0]  CLK_BUS       = 2'h1;
  localparam logic [1:0]  CLK_FIXED     = 2'h2;
  localparam logic [1:0]  CLK_EXT       = 2'h3;

  localparam logic [1:0]  ELS_OFF       = 2'h0;
  localparam logic [1:0]  ELS_TOGGLE    = 2'h1;
  localparam logic [1:0]  ELS_CLEAR     = 2'h2;
  localparam logic [1:0]  ELS_SET       = 2'h3;
  localparam logic [1:0]  ELS_RISE      = 2'h1;
  localparam logic [1:0]  ELS_FALL      = 2'h2;

  localparam logic [1:0]  MODE_CAPTURE  = 2'h0;
  localparam logic [1:0]  MODE_COMPARE  = 2'h1;

  localparam logic        PIN_INIT      = 1'b0;

  typedef struct packed {
    logic [1:0]       channel_mode_select;
    logic [1:0]       edge_level_select;
    logic [CNT_W-1:0] channel_value;
  } tpc_ch_cfg_t;

  typedef struct packed {
    logic             count_tick;
    logic             count_down;
    logic [CNT_W-1:0] counter_value;
  } tpc_cnt_t;

endpackage
